// *** rtl/dcam_defs.svh ***
// Purpose: Constants for the data channel output and add-to-memory block
// Assumes: 50 MHz clock, 18-bit data words, 15-bit word addresses
// Notes: Widths, timing, register offsets and service codes follow
`ifndef DCAM_DEFS_SVH
`define DCAM_DEFS_SVH
`define DCAM_DW 18
`define DCAM_AW 15
`define DCAM_CLK_NS 20
`define DCAM_RESTART_NS 400
`define DCAM_RESTART_CYC ((`DCAM_RESTART_NS + `DCAM_CLK_NS - 1) / `DCAM_CLK_NS)
`define DCAM_SUM_PULSE_US 200
`define DCAM_SUM_PULSE_CYC (`DCAM_SUM_PULSE_US * 1000 / `DCAM_CLK_NS)
`define DCAM_OFF_CTRL 12'h000
`define DCAM_OFF_STATUS 12'h004
`define DCAM_OFF_MADDR 12'h008
`define DCAM_OFF_MDATA 12'h00c
`define DCAM_CTRL_EN 0
`define DCAM_ST_WCOV 8
`define DCAM_ST_SUMOV 9
`define DCAM_SVC_DCH 3'h4
`define DCAM_SVC_RTC 3'h3
`define DCAM_SVC_API 3'h2
`define DCAM_SVC_PI 3'h1
`define DCAM_SVC_MAIN 3'h0
`endif

// *** rtl/dcam_pkg.sv ***
// Purpose: Types for the data channel output and add-to-memory block
// Assumes: dcam_defs.svh widths
// Notes: One packed struct holds all sequencer state
`default_nettype none
`include "dcam_defs.svh"
package dcam_pkg;
    typedef enum logic [3:0] {
        ST_MAIN = 4'h0,
        ST_WC = 4'h1,
        ST_CA = 4'h2,
        ST_DAT1 = 4'h3,
        ST_DAT2 = 4'h4,
        ST_IDLE = 4'h5,
        ST_DLY = 4'h6,
        ST_INCEND = 4'h7,
        ST_INSTR = 4'h8
    } dcam_state_t;
    typedef struct packed {
        dcam_state_t st;
        logic [1:0] bk;
        logic sync;
        logic saved_sync;
        logic grant;
        logic addr_gate;
        logic xfer_gate;
        logic io_pulse_two;
        logic io_pulse_four;
        logic strobe4;
        logic bus_on;
        logic done;
        logic wc_oflo;
        logic sum_oflo;
        logic wc_flag;
        logic sum_flag;
        logic add_ov;
        logic pend;
        logic enable;
        logic pready;
        logic pslverr;
        logic [`DCAM_DW-1:0] operand;
        logic [`DCAM_DW-1:0] mb;
        logic [`DCAM_DW-1:0] dout;
        logic [`DCAM_AW-1:0] wa;
        logic [`DCAM_AW-1:0] ca;
        logic [`DCAM_AW-1:0] maddr;
        logic [31:0] prdata;
        logic [15:0] dly_cnt;
        logic [15:0] sum_cnt;
        logic [2:0] svc;
    } dcam_st_t;
endpackage
`default_nettype wire

// *** rtl/dcam_top.sv ***
// Purpose: Data channel break sequencer for output, increment-only and add-to-memory
// Assumes: Inputs synchronous to CLK; each break cycle takes one clock
// Notes: Core memory is an internal array reached also over APB
`default_nettype none
`include "dcam_defs.svh"
module dcam_top #(
    parameter int DEPTH = 1024,
    parameter int SUM_PULSE_CYC = `DCAM_SUM_PULSE_CYC
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CHANNEL_REQUEST,
    input wire logic READ_REQUEST,
    input wire logic WRITE_REQUEST_LINE,
    input wire logic INCREMENT_ONLY_REQUEST,
    input wire logic [`DCAM_AW-1:0] IO_ADDR,
    input wire logic [`DCAM_DW-1:0] IO_DATA_IN,
    input wire logic RTC_REQUEST,
    input wire logic AUTO_PRIORITY_INTERRUPT,
    input wire logic PROGRAM_INTERRUPT,
    output logic CHANNEL_GRANT,
    output logic CHANNEL_SYNC,
    output logic SAVED_CHANNEL_SYNC,
    output logic ADDR_PHASE_GATE,
    output logic XFER_PHASE_GATE,
    output logic IO_PULSE_TWO,
    output logic DEVICE_STROBE_FOUR,
    output logic IO_BUS_ON,
    output logic [`DCAM_DW-1:0] IO_DATA_OUT,
    output logic [1:0] BREAK_COUNT,
    output logic WORD_COUNT_OVERFLOW,
    output logic SUM_OVERFLOW,
    output logic INSTR_DONE,
    output logic [2:0] SERVICE_SEL
);
    import dcam_pkg::*;

    localparam int RCYC = `DCAM_RESTART_CYC;

    if (DEPTH < 2 || DEPTH > 32768 || (DEPTH & (DEPTH - 1)) != 0) begin
        $error("DEPTH must be a power of two from 2 to 32768");
    end
    if (SUM_PULSE_CYC < 1 || SUM_PULSE_CYC > 65535) begin
        $error("SUM_PULSE_CYC out of range");
    end

    localparam int IW = $clog2(DEPTH);

    logic [`DCAM_DW-1:0] mem [DEPTH];
    dcam_st_t r;
    dcam_st_t n;
    logic mem_we;
    logic [IW-1:0] mem_wa;
    logic [`DCAM_DW-1:0] mem_wd;
    logic [`DCAM_DW-1:0] rd_wc;
    logic [`DCAM_DW-1:0] rd_ca;
    logic [`DCAM_DW-1:0] rd_dat;
    logic [`DCAM_DW-1:0] a_bus;
    logic [`DCAM_DW-1:0] b_bus;
    logic [`DCAM_DW-1:0] sum;
    logic [`DCAM_DW-1:0] inc;
    logic [`DCAM_AW-1:0] ca_addr;
    logic setup;
    logic commit;
    logic ack_wc;
    logic ack_sum;

    assign ca_addr = IO_ADDR + `DCAM_AW'(1);
    assign rd_wc = mem[IO_ADDR[IW-1:0]];
    assign rd_ca = mem[ca_addr[IW-1:0]];
    assign rd_dat = mem[r.ca[IW-1:0]];

    always_comb begin
        n = r;
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = '0;
        a_bus = '0;
        b_bus = '0;
        sum = '0;
        inc = '0;
        n.io_pulse_two = 1'b0;
        n.strobe4 = 1'b0;
        n.done = 1'b0;
        n.wc_oflo = 1'b0;
        // Fixed service order
        if (CHANNEL_REQUEST) n.svc = `DCAM_SVC_DCH;
        else if (RTC_REQUEST) n.svc = `DCAM_SVC_RTC;
        else if (AUTO_PRIORITY_INTERRUPT) n.svc = `DCAM_SVC_API;
        else if (PROGRAM_INTERRUPT && !r.saved_sync) n.svc = `DCAM_SVC_PI;
        else n.svc = `DCAM_SVC_MAIN;
        unique case (r.st)
            ST_MAIN: begin
                n.done = 1'b1;
                n.xfer_gate = 1'b0;
                if (r.enable && (CHANNEL_REQUEST || r.pend)) begin
                    // Peripheral withdraws its request on grant
                    n.pend = 1'b0;
                    n.sync = 1'b1;
                    n.saved_sync = 1'b1;
                    n.grant = 1'b1;
                    n.addr_gate = 1'b1;
                    n.st = ST_WC;
                end
            end
            ST_WC: begin
                n.xfer_gate = 1'b1;
                n.bk = 2'b10;
                n.wa = IO_ADDR;
                inc = rd_wc + `DCAM_DW'(1);
                mem_we = 1'b1;
                mem_wa = IO_ADDR[IW-1:0];
                mem_wd = inc;
                n.mb = inc;
                if (inc == '0) begin
                    n.wc_oflo = 1'b1;
                    n.wc_flag = 1'b1;
                end
                if (INCREMENT_ONLY_REQUEST) begin
                    n.done = 1'b1;
                    n.st = ST_INCEND;
                end else begin
                    n.st = ST_CA;
                end
            end
            ST_INCEND: begin
                n.bk = 2'b00;
                n.sync = 1'b0;
                n.grant = 1'b0;
                n.addr_gate = 1'b0;
                n.st = ST_INSTR;
            end
            ST_INSTR: begin
                // One main instruction completes before the next break
                n.xfer_gate = 1'b0;
                n.saved_sync = 1'b0;
                n.done = 1'b1;
                n.pend = CHANNEL_REQUEST;
                n.st = ST_MAIN;
            end
            ST_CA: begin
                n.bk = 2'b11;
                inc = rd_ca + `DCAM_DW'(1);
                mem_we = 1'b1;
                mem_wa = ca_addr[IW-1:0];
                mem_wd = inc;
                n.ca = inc[`DCAM_AW-1:0];
                n.pend = CHANNEL_REQUEST;
                if (READ_REQUEST) begin
                    n.io_pulse_two = 1'b1;
                    n.operand = IO_DATA_IN;
                end else begin
                    n.operand = '0;
                end
                if (!WRITE_REQUEST_LINE) begin
                    n.sync = 1'b0;
                    n.grant = 1'b0;
                end
                n.st = ST_DAT1;
            end
            ST_DAT1: begin
                n.bk = 2'b01;
                // Memory word gated on B side unless pure input
                if (WRITE_REQUEST_LINE) b_bus = rd_dat;
                // Operand gated on A side only with read request
                if (READ_REQUEST) a_bus = r.operand;
                sum = a_bus + b_bus;
                n.mb = sum;
                n.add_ov = READ_REQUEST && WRITE_REQUEST_LINE
                    && (a_bus[`DCAM_DW-1] == b_bus[`DCAM_DW-1])
                    && (sum[`DCAM_DW-1] != a_bus[`DCAM_DW-1]);
                if (READ_REQUEST) begin
                    mem_we = 1'b1;
                    mem_wa = r.ca[IW-1:0];
                    mem_wd = sum;
                end
                if (WRITE_REQUEST_LINE) begin
                    n.sync = 1'b0;
                    n.grant = 1'b0;
                end
                n.st = ST_DAT2;
            end
            ST_DAT2: begin
                n.dout = r.mb;
                // Bus drive only for transfers that send a word out
                n.bus_on = WRITE_REQUEST_LINE;
                n.addr_gate = 1'b0;
                if (WRITE_REQUEST_LINE) begin
                    n.st = ST_IDLE;
                end else begin
                    n.bk = 2'b00;
                    n.saved_sync = 1'b0;
                    n.st = ST_MAIN;
                end
            end
            ST_IDLE: begin
                // No memory cycle; bus word settles
                n.addr_gate = 1'b0;
                n.bk = 2'b00;
                n.io_pulse_four = 1'b1;
                n.strobe4 = r.xfer_gate;
                n.dly_cnt = 16'(RCYC);
                if (r.add_ov) begin
                    n.sum_oflo = 1'b1;
                    n.sum_flag = 1'b1;
                    n.sum_cnt = 16'(SUM_PULSE_CYC);
                end
                n.st = ST_DLY;
            end
            ST_DLY: begin
                if (r.dly_cnt <= 16'h0001) begin
                    n.io_pulse_four = 1'b0;
                    n.saved_sync = 1'b0;
                    n.bus_on = 1'b0;
                    n.add_ov = 1'b0;
                    n.st = ST_MAIN;
                end else begin
                    n.dly_cnt = r.dly_cnt - 16'h0001;
                end
            end
            default: n.st = ST_MAIN;
        endcase
        if (r.sum_cnt != 16'h0000 && r.st != ST_IDLE) begin
            n.sum_cnt = r.sum_cnt - 16'h0001;
            if (r.sum_cnt == 16'h0001) n.sum_oflo = 1'b0;
        end
        // APB slave, one wait state
        setup = PSEL && PENABLE && !r.pready;
        commit = PSEL && PENABLE && r.pready;
        n.pready = setup;
        n.pslverr = 1'b0;
        ack_wc = 1'b0;
        ack_sum = 1'b0;
        if (setup) begin
            n.pslverr = 1'b0;
            n.prdata = '0;
            case (PADDR)
                `DCAM_OFF_CTRL: n.prdata[`DCAM_CTRL_EN] = r.enable;
                `DCAM_OFF_STATUS: begin
                    n.prdata[3:0] = r.st;
                    n.prdata[5:4] = r.bk;
                    n.prdata[6] = r.sync;
                    n.prdata[`DCAM_ST_WCOV] = r.wc_flag;
                    n.prdata[`DCAM_ST_SUMOV] = r.sum_flag;
                end
                `DCAM_OFF_MADDR: n.prdata[`DCAM_AW-1:0] = r.maddr;
                `DCAM_OFF_MDATA: n.prdata[`DCAM_DW-1:0] = mem[r.maddr[IW-1:0]];
                default: n.pslverr = 1'b1;
            endcase
            if (PWRITE && PADDR == `DCAM_OFF_MDATA && r.st != ST_MAIN)
                n.pslverr = 1'b1;
        end
        if (commit && PWRITE && !r.pslverr) begin
            case (PADDR)
                `DCAM_OFF_CTRL: n.enable = PWDATA[`DCAM_CTRL_EN];
                `DCAM_OFF_STATUS: begin
                    ack_wc = PWDATA[`DCAM_ST_WCOV];
                    ack_sum = PWDATA[`DCAM_ST_SUMOV];
                end
                `DCAM_OFF_MADDR: n.maddr = PWDATA[`DCAM_AW-1:0];
                `DCAM_OFF_MDATA: begin
                    if (!mem_we) begin
                        mem_we = 1'b1;
                        mem_wa = r.maddr[IW-1:0];
                        mem_wd = PWDATA[`DCAM_DW-1:0];
                    end
                end
                default: ;
            endcase
        end
        // Hardware set wins over software clear
        if (ack_wc && !n.wc_oflo) n.wc_flag = 1'b0;
        if (ack_sum && !(r.st == ST_IDLE && r.add_ov)) n.sum_flag = 1'b0;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            r <= '0;
            r.st <= ST_MAIN;
        end else if (CE) begin
            r <= n;
        end
    end

    always_ff @(posedge CLK) begin
        if (CE && mem_we) mem[mem_wa] <= mem_wd;
    end

    assign PRDATA = r.prdata;
    assign PREADY = r.pready;
    assign PSLVERR = r.pslverr;
    assign CHANNEL_GRANT = r.grant;
    assign CHANNEL_SYNC = r.sync;
    assign SAVED_CHANNEL_SYNC = r.saved_sync;
    assign ADDR_PHASE_GATE = r.addr_gate;
    assign XFER_PHASE_GATE = r.xfer_gate;
    assign IO_PULSE_TWO = r.io_pulse_two;
    assign DEVICE_STROBE_FOUR = r.strobe4;
    assign IO_BUS_ON = r.bus_on;
    assign IO_DATA_OUT = r.dout;
    assign BREAK_COUNT = r.bk;
    assign WORD_COUNT_OVERFLOW = r.wc_oflo;
    assign SUM_OVERFLOW = r.sum_oflo;
    assign INSTR_DONE = r.done;
    assign SERVICE_SEL = r.svc;
endmodule
`default_nettype wire

// *** verif/dcam_props.sv ***
// Purpose: Port-level checker for dcam_top
// Assumes: Single clock domain, NRST synchronous active low
// Notes: Bound to dcam_top below
`default_nettype none
`include "dcam_defs.svh"
module dcam_props #(
    parameter int SUM_PULSE_CYC = 8
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic READ_REQUEST,
    input wire logic CHANNEL_GRANT,
    input wire logic CHANNEL_SYNC,
    input wire logic SAVED_CHANNEL_SYNC,
    input wire logic ADDR_PHASE_GATE,
    input wire logic XFER_PHASE_GATE,
    input wire logic IO_PULSE_TWO,
    input wire logic DEVICE_STROBE_FOUR,
    input wire logic IO_BUS_ON,
    input wire logic [`DCAM_DW-1:0] IO_DATA_OUT,
    input wire logic [1:0] BREAK_COUNT,
    input wire logic SUM_OVERFLOW
);
    logic [15:0] dly_cnt;
    logic [15:0] sov_cnt;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Cycles since the strobe, and length of the overflow pulse
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            dly_cnt <= 16'h0;
            sov_cnt <= 16'h0;
        end else begin
            if (DEVICE_STROBE_FOUR) dly_cnt <= 16'h1;
            else if (SAVED_CHANNEL_SYNC && dly_cnt != 16'h0) dly_cnt <= dly_cnt + 16'h1;
            else dly_cnt <= 16'h0;
            sov_cnt <= SUM_OVERFLOW ? sov_cnt + 16'h1 : 16'h0;
        end
    end
    a_grant_entry: assert property ($rose(CHANNEL_GRANT) |-> CHANNEL_SYNC && ADDR_PHASE_GATE
        ##1 XFER_PHASE_GATE && BREAK_COUNT == 2'b10) else $error("break entry order wrong");
    a_pulse_two: assert property ((BREAK_COUNT == 2'b11 && $past(BREAK_COUNT) == 2'b10)
        |-> IO_PULSE_TWO == $past(READ_REQUEST)) else $error("pulse two mismatch");
    a_sync_drop: assert property (BREAK_COUNT == 2'b01 |-> !CHANNEL_SYNC && !CHANNEL_GRANT)
        else $error("sync held at count 01");
    a_bus_hold: assert property (IO_BUS_ON && $past(IO_BUS_ON) |-> $stable(IO_DATA_OUT))
        else $error("bus data moved");
    a_idle_cycle: assert property ($rose(IO_BUS_ON) |-> !ADDR_PHASE_GATE
        && BREAK_COUNT == 2'b01 ##1 DEVICE_STROBE_FOUR) else $error("idle cycle wrong");
    a_strobe_four: assert property (DEVICE_STROBE_FOUR |-> BREAK_COUNT == 2'b00
        && $past(BREAK_COUNT) == 2'b01 && IO_BUS_ON && XFER_PHASE_GATE) else $error("bad strobe");
    a_restart_wait: assert property ($fell(SAVED_CHANNEL_SYNC) && $past(IO_BUS_ON)
        |-> dly_cnt >= 16'd20 && dly_cnt <= 16'd22) else $error("restart delay wrong");
    a_xfer_clear: assert property ($fell(SAVED_CHANNEL_SYNC) && $past(IO_BUS_ON)
        |-> !IO_BUS_ON ##[1:2] !XFER_PHASE_GATE) else $error("transfer gate stays");
    a_inc_end: assert property ($fell(CHANNEL_SYNC) && BREAK_COUNT == 2'b00
        |-> !CHANNEL_GRANT && !ADDR_PHASE_GATE ##1 !XFER_PHASE_GATE) else $error("inc end wrong");
    a_sum_start: assert property ($rose(SUM_OVERFLOW)
        |-> DEVICE_STROBE_FOUR && $past(IO_PULSE_TWO, 3)) else $error("overflow outside add");
    a_sum_width: assert property ($fell(SUM_OVERFLOW) |-> sov_cnt == SUM_PULSE_CYC)
        else $error("overflow pulse width");
    c_strobe: cover property (DEVICE_STROBE_FOUR);
    c_sum: cover property ($rose(SUM_OVERFLOW));
    c_inc: cover property ($fell(CHANNEL_SYNC) && BREAK_COUNT == 2'b00);
endmodule
bind dcam_top dcam_props #(.SUM_PULSE_CYC(SUM_PULSE_CYC)) dcam_props_inst (
    .CLK(CLK), .NRST(NRST), .READ_REQUEST(READ_REQUEST), .CHANNEL_GRANT(CHANNEL_GRANT),
    .CHANNEL_SYNC(CHANNEL_SYNC), .SAVED_CHANNEL_SYNC(SAVED_CHANNEL_SYNC),
    .ADDR_PHASE_GATE(ADDR_PHASE_GATE), .XFER_PHASE_GATE(XFER_PHASE_GATE),
    .IO_PULSE_TWO(IO_PULSE_TWO), .DEVICE_STROBE_FOUR(DEVICE_STROBE_FOUR),
    .IO_BUS_ON(IO_BUS_ON), .IO_DATA_OUT(IO_DATA_OUT), .BREAK_COUNT(BREAK_COUNT),
    .SUM_OVERFLOW(SUM_OVERFLOW));
`default_nettype wire

// *** verif/dcam_periph.sv ***
// Purpose: Channel peripheral model
// Assumes: Flag raised by go, nreq words requested back to back
// Notes: Released lines show the inverse value
`default_nettype none
`include "dcam_defs.svh"
module dcam_periph #(
    parameter logic [`DCAM_AW-1:0] WC = 15'h0010
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic [1:0] mode,
    input wire logic [1:0] nreq,
    input wire logic [`DCAM_DW-1:0] data,
    input wire logic grant,
    input wire logic agate,
    input wire logic xgate,
    input wire logic strobe4,
    input wire logic bus_on,
    input wire logic [`DCAM_DW-1:0] dout,
    output logic req,
    output logic rd,
    output logic wr,
    output logic inc,
    output logic [`DCAM_AW-1:0] io_addr,
    output logic [`DCAM_DW-1:0] io_din,
    output logic [`DCAM_DW-1:0] captured,
    output logic [1:0] pend
);
    logic grant_d;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pend <= 2'h0;
            grant_d <= 1'b0;
            captured <= '0;
        end else begin
            grant_d <= grant;
            if (go) pend <= nreq;
            else if (grant && !grant_d) pend <= pend - 2'h1;
            if (strobe4 && bus_on) captured <= dout;
        end
    end
    assign req = (pend != 2'h0) && !grant;
    assign inc = agate && mode == 2'h2;
    assign io_addr = agate ? WC : ~WC;
    assign rd = xgate && mode == 2'h1;
    assign wr = xgate && mode != 2'h2;
    assign io_din = rd ? data : ~data;
endmodule
`default_nettype wire

// *** verif/test_data_channel_output_and_add_to_memory.sv ***
// Purpose: Self-checking bench for dcam_top
// Assumes: APB access to memory, peripheral model on the channel
// Notes: Short overflow pulse keeps the run brief
`default_nettype none
`include "dcam_defs.svh"
module test_data_channel_output_and_add_to_memory;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic rtc = 1'b0, apint = 1'b0, pint = 1'b0, e, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [1:0] mode = 2'h0, nreq = 2'h0, pend, bk;
    logic [17:0] dev_data = 18'h0, captured, dout, din, s;
    logic [14:0] io_addr;
    logic [2:0] sel, dch_sel;
    logic req, rdq, wrq, incq, grant, sync, saved, agate, xgate, io_pulse_two, st4, bus_on;
    logic wcov, sov, idone, grant_d = 1'b0, wcov_seen = 1'b0, sov_seen = 1'b0;
    logic [17:0] ma[4] = '{18'h1ffff, 18'h20000, 18'h1ffff, 18'h00005};
    logic [17:0] da[4] = '{18'h00001, 18'h3ffff, 18'h20000, 18'h3fffd};
    logic ovs[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic [2:0] pri[4] = '{3'b000, 3'b001, 3'b011, 3'b111};
    int n_errors = 0, tests_run = 0, gap = 0, main_run = 0;
    dcam_top #(.SUM_PULSE_CYC(8)) dcam_top_inst (
        .CLK(clk), .NRST(nrst), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CHANNEL_REQUEST(req), .READ_REQUEST(rdq), .WRITE_REQUEST_LINE(wrq),
        .INCREMENT_ONLY_REQUEST(incq), .IO_ADDR(io_addr), .IO_DATA_IN(din),
        .RTC_REQUEST(rtc), .AUTO_PRIORITY_INTERRUPT(apint), .PROGRAM_INTERRUPT(pint),
        .CHANNEL_GRANT(grant), .CHANNEL_SYNC(sync), .SAVED_CHANNEL_SYNC(saved),
        .ADDR_PHASE_GATE(agate), .XFER_PHASE_GATE(xgate), .IO_PULSE_TWO(io_pulse_two),
        .DEVICE_STROBE_FOUR(st4), .IO_BUS_ON(bus_on), .IO_DATA_OUT(dout), .BREAK_COUNT(bk),
        .WORD_COUNT_OVERFLOW(wcov), .SUM_OVERFLOW(sov), .INSTR_DONE(idone), .SERVICE_SEL(sel));
    dcam_periph dcam_periph_inst (
        .clk(clk), .nrst(nrst), .go(go), .mode(mode), .nreq(nreq), .data(dev_data),
        .grant(grant), .agate(agate), .xgate(xgate), .strobe4(st4), .bus_on(bus_on),
        .dout(dout), .req(req), .rd(rdq), .wr(wrq), .inc(incq), .io_addr(io_addr),
        .io_din(din), .captured(captured), .pend(pend));
    initial begin
        forever #10 clk = ~clk;
    end
    // Sticky event flags, main cycles between breaks, selection during a break
    always @(posedge clk) begin
        if (wcov === 1'b1) wcov_seen <= 1'b1;
        if (go) sov_seen <= 1'b0;
        else if (sov === 1'b1) sov_seen <= 1'b1;
        if (grant) main_run <= 0;
        else if (idone) main_run <= main_run + 1;
        if (grant && !grant_d) gap <= main_run;
        if (grant && !grant_d) dch_sel <= sel;
        grant_d <= grant;
    end
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    task automatic mem_wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, `DCAM_OFF_MADDR, a);
        apb(1'b1, `DCAM_OFF_MDATA, d);
    endtask
    task automatic mem_rd(input logic [31:0] a);
        apb(1'b1, `DCAM_OFF_MADDR, a);
        apb(1'b0, `DCAM_OFF_MDATA, 32'h0);
    endtask
    task automatic brk(input logic [1:0] m, input logic [1:0] n, input logic [17:0] d);
        int k;
        mode <= m;
        nreq <= n;
        dev_data <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!(pend === 2'h0 && !grant && !xgate && idone === 1'b1) && k < 300);
        if (k >= 300) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, 12'h010, 32'h0);
        check(32'(e), 32'h1);
        apb(1'b1, `DCAM_OFF_CTRL, 32'h1);
        mem_wr(32'h10, 32'h3ffff);
        mem_wr(32'h11, 32'h0ff);
        mem_wr(32'h100, 32'h2a5a5);
        brk(2'h0, 2'h1, 18'h15555);
        check(32'(captured), 32'h2a5a5);
        check(32'(sov_seen), 32'h0);
        check(32'(wcov_seen), 32'h1);
        mem_rd(32'h100);
        check(q, 32'h2a5a5);
        for (int i = 0; i < 4; i++) begin
            s = ma[i] + da[i];
            mem_wr(32'h10, 32'h5);
            mem_wr(32'h11, 32'h1ff);
            mem_wr(32'h200, 32'(ma[i]));
            brk(2'h1, 2'h1, da[i]);
            mem_rd(32'h200);
            check(q, 32'(s));
            check(32'(captured), 32'(s));
            check(32'(sov_seen), 32'(ovs[i]));
            apb(1'b0, `DCAM_OFF_STATUS, 32'h0);
            check(32'(q[9]), 32'(ovs[i]));
            apb(1'b1, `DCAM_OFF_STATUS, 32'h300);
        end
        for (int i = 0; i < 4; i++) begin
            {rtc, apint, pint} <= pri[i];
            repeat (3) @(posedge clk);
            check(32'(sel), 32'(i));
        end
        mem_wr(32'h10, 32'h7);
        mem_wr(32'h11, 32'h1ff);
        brk(2'h2, 2'h2, 18'h0);
        check(32'(dch_sel), 32'h4);
        check(32'(gap), 32'h1);
        mem_rd(32'h10);
        check(q, 32'h9);
        mem_rd(32'h11);
        check(q, 32'h1ff);
        tally_and_finish();
    end
endmodule
`default_nettype wire
